// ---- logic/fpp_programmer.v ----
// Programmer that opens PROM fuses bit by bit and verifies the array
`include "fpp_consts.vh"
module fpp_programmer #(
  parameter FIRST_CYC = `FPP_FIRST_PULSE_CYC,
  parameter NEXT_CYC = `FPP_NEXT_PULSE_CYC,
  parameter BIT_LIMIT_CYC = `FPP_BIT_LIMIT_CYC,
  parameter HOT_LIMIT_CYC = `FPP_HOT_LIMIT_CYC,
  parameter COOL_CYC = `FPP_COOL_CYC,
  parameter STEP_CYC = `FPP_STEP_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire prog_start,
  input wire [`FPP_ADDR_W-1:0] prog_addr,
  input wire [2:0] prog_bit,
  output wire prog_ready,
  input wire check_start,
  input wire [`FPP_ADDR_W-1:0] check_addr,
  output wire check_ready,
  output reg [`FPP_DATA_W-1:0] check_data,
  output reg check_valid,
  output reg done_ok,
  output reg done_fail,
  output reg [`FPP_ADDR_W-1:0] word_sel_lines,
  output reg reg_clock_pin,
  output reg sync_output_gate,
  output reg async_gate_high,
  output reg gate_overdrive_level,
  output reg fuse_blow_supply,
  output reg [`FPP_DATA_W-1:0] supply_bit_sel,
  output reg load_sel,
  output reg power_on,
  input wire [`FPP_DATA_W-1:0] data_out_bus
);
  localparam S_IDLE = 12'h001;
  localparam S_GATE = 12'h002;
  localparam S_SUPPLY = 12'h004;
  localparam S_PULSE = 12'h008;
  localparam S_DROP = 12'h010;
  localparam S_ENABLE = 12'h020;
  localparam S_CLKHI = 12'h040;
  localparam S_SENSE = 12'h080;
  localparam S_COOL = 12'h100;
  localparam S_RDSET = 12'h200;
  localparam S_RDCLK = 12'h400;
  localparam S_RDGET = 12'h800;

  reg [11:0] state;
  reg [11:0] next_state;
  reg [`FPP_ADDR_W-1:0] cur_addr;
  reg [2:0] cur_bit;
  reg first_try;
  reg [7:0] step;
  wire step_done = (step == 8'h00);
  wire pulse_done;
  wire cool_done;
  wire bit_over;
  wire hot_over;
  reg tmr_load;
  reg [31:0] tmr_count;
  reg dev_dead;
  wire sensed_high = data_out_bus[cur_bit];
  wire dead_refuse = (state == S_IDLE) && !check_start && prog_start && dev_dead;

  function [`FPP_DATA_W-1:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = {{(`FPP_DATA_W-1){1'b0}}, 1'b1} << b;
    end
  endfunction

  function in_set;
    input [11:0] st;
    input [11:0] mask;
    begin
      in_set = (st & mask) != 12'h000;
    end
  endfunction

  // Check wins so a final readback is never starved
  assign prog_ready = (state == S_IDLE) && !check_start;
  assign check_ready = (state == S_IDLE);

  // One timer serves pulses and cooling; never both at once
  fpp_timer #(.W(32)) u_tmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .busy(),
    .done(pulse_done)
  );
  assign cool_done = pulse_done;

  // Total pulse time on the current bit
  fpp_accum #(.W(32)) u_bit (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(state == S_IDLE),
    .run(state == S_PULSE),
    .limit(BIT_LIMIT_CYC),
    .over(bit_over)
  );

  // Continuous busy time, programming and readback, reset only by a cool-down
  // Idle gaps are too short to cool the part, so they pause the count but do not clear it
  fpp_accum #(.W(32)) u_hot (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(state == S_COOL),
    .run(state != S_IDLE && state != S_COOL),
    .limit(HOT_LIMIT_CYC),
    .over(hot_over)
  );

  always @* begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = 32'h00000000;
    case (state)
      S_IDLE: begin
        if (check_start) begin
          next_state = S_RDSET;
        end else if (prog_start && !dev_dead) begin
          next_state = S_GATE;
        end
      end
      S_GATE: begin
        if (step_done) begin
          next_state = S_SUPPLY;
        end
      end
      S_SUPPLY: begin
        if (step_done) begin
          next_state = S_PULSE;
          tmr_load = 1'b1;
          tmr_count = first_try ? FIRST_CYC : NEXT_CYC;
        end
      end
      S_PULSE: begin
        if (pulse_done) begin
          next_state = S_DROP;
        end
      end
      S_DROP: begin
        if (step_done) begin
          next_state = S_ENABLE;
        end
      end
      S_ENABLE: begin
        if (step_done) begin
          next_state = S_CLKHI;
        end
      end
      S_CLKHI: begin
        if (step_done) begin
          next_state = S_SENSE;
        end
      end
      S_SENSE: begin
        // An opened fuse counts as success even past the time limit
        if (step_done) begin
          if (sensed_high) begin
            next_state = S_IDLE;
          end else if (bit_over) begin
            next_state = S_IDLE;
          end else if (hot_over) begin
            next_state = S_COOL;
            tmr_load = 1'b1;
            tmr_count = COOL_CYC;
          end else begin
            next_state = S_GATE;
          end
        end
      end
      S_COOL: begin
        if (cool_done) begin
          next_state = S_GATE;
        end
      end
      S_RDSET: begin
        if (step_done) begin
          next_state = S_RDCLK;
        end
      end
      S_RDCLK: begin
        if (step_done) begin
          next_state = S_RDGET;
        end
      end
      S_RDGET: begin
        if (step_done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      step <= 8'h00;
      cur_addr <= {`FPP_ADDR_W{1'b0}};
      cur_bit <= 3'h0;
      first_try <= 1'b1;
      check_data <= {`FPP_DATA_W{1'b0}};
      check_valid <= 1'b0;
      done_ok <= 1'b0;
      done_fail <= 1'b0;
    end else begin
      state <= next_state;
      check_valid <= 1'b0;
      done_ok <= 1'b0;
      done_fail <= 1'b0;
      // Step spacing keeps each edge gap above 100 ns and short
      if (next_state != state) begin
        step <= STEP_CYC[7:0] - 8'h01;
      end else if (!step_done) begin
        step <= step - 8'h01;
      end
      if (state == S_IDLE && check_start) begin
        cur_addr <= check_addr;
      end else if (state == S_IDLE && prog_start) begin
        cur_addr <= prog_addr;
        cur_bit <= prog_bit;
        first_try <= 1'b1;
      end
      if (state == S_PULSE && pulse_done) begin
        first_try <= 1'b0;
      end
      if (state == S_SENSE && step_done) begin
        done_ok <= sensed_high;
        done_fail <= !sensed_high && bit_over;
      end
      if (dead_refuse) begin
        done_fail <= 1'b1;
      end
      if (state == S_RDGET && step_done) begin
        check_data <= data_out_bus;
        check_valid <= 1'b1;
      end
    end
  end

  // A device that kept a fuse past the limit is spent until reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_dead <= 1'b0;
    end else if (state == S_SENSE && step_done && !sensed_high && bit_over) begin
      dev_dead <= 1'b1;
    end
  end

  // Control pins decoded from next_state, address and bit lines from cur_addr and cur_bit, all held in flip-flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_sel_lines <= {`FPP_ADDR_W{1'b0}};
      reg_clock_pin <= 1'b0;
      sync_output_gate <= 1'b1;
      async_gate_high <= 1'b1;
      gate_overdrive_level <= 1'b0;
      fuse_blow_supply <= 1'b0;
      supply_bit_sel <= {`FPP_DATA_W{1'b0}};
      load_sel <= 1'b0;
      power_on <= 1'b1;
    end else begin
      word_sel_lines <= cur_addr;
      supply_bit_sel <= bit_mask(cur_bit);
      power_on <= (next_state != S_COOL);
      async_gate_high <= in_set(next_state, S_GATE | S_SUPPLY | S_PULSE | S_DROP);
      // Supply and overdrive fall on one edge so fuse current stops at once
      fuse_blow_supply <= in_set(next_state, S_SUPPLY | S_PULSE);
      gate_overdrive_level <= (next_state == S_PULSE);
      sync_output_gate <= !in_set(next_state, S_ENABLE | S_CLKHI | S_SENSE | S_RDSET
        | S_RDCLK | S_RDGET);
      reg_clock_pin <= in_set(next_state, S_CLKHI | S_SENSE | S_RDCLK | S_RDGET);
      load_sel <= in_set(next_state, S_ENABLE | S_CLKHI | S_SENSE);
    end
  end
endmodule

// ---- pkg/fpp_consts.vh ----
// Constants for the fuse PROM programmer controller
`ifndef FPP_CONSTS_VH
`define FPP_CONSTS_VH
`define FPP_CLK_MHZ 10
`define FPP_ADDR_W 9
`define FPP_DATA_W 8
`define FPP_WORDS 512
`define FPP_FIRST_PULSE_US 75
`define FPP_FIRST_PULSE_CYC (`FPP_FIRST_PULSE_US * `FPP_CLK_MHZ)
`define FPP_NEXT_PULSE_MS 5
`define FPP_NEXT_PULSE_CYC (`FPP_NEXT_PULSE_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_BIT_LIMIT_MS 400
`define FPP_BIT_LIMIT_CYC (`FPP_BIT_LIMIT_MS * 1000 * `FPP_CLK_MHZ)
`define FPP_HOT_LIMIT_S 5
`define FPP_HOT_LIMIT_CYC (`FPP_HOT_LIMIT_S * 1000000 * `FPP_CLK_MHZ)
`define FPP_COOL_S 5
`define FPP_COOL_CYC (`FPP_COOL_S * 1000000 * `FPP_CLK_MHZ)
`define FPP_STEP_NS 500
`define FPP_STEP_CYC ((`FPP_STEP_NS + 99) / 100)
`endif

// ---- logic/fpp_timer.v ----
// Down-counting one-shot timer with done pulse
module fpp_timer #(
  parameter W = 32
) (
  input wire ref_clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] count,
  output reg busy,
  output wire done
);
  reg [W-1:0] left;
  assign done = busy && (left == {{(W-1){1'b0}}, 1'b1});
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= {W{1'b0}};
      busy <= 1'b0;
    end else if (load) begin
      left <= count;
      busy <= 1'b1;
    end else if (busy) begin
      left <= left - {{(W-1){1'b0}}, 1'b1};
      if (left == {{(W-1){1'b0}}, 1'b1}) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- logic/fpp_accum.v ----
// Accumulating time counter with limit flag
module fpp_accum #(
  parameter W = 32
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clear,
  input wire run,
  input wire [W-1:0] limit,
  output wire over
);
  reg [W-1:0] total;
  assign over = (total >= limit);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      total <= {W{1'b0}};
    end else if (clear) begin
      total <= {W{1'b0}};
    end else if (run && !over) begin
      total <= total + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ---- sim/fpp_programmer_assertions.sv ----
// Pin sequencing checks for the fuse programmer
module fpp_programmer_chk #(
  parameter FIRST_CYC = 750,
  parameter NEXT_CYC = 200
) (
  input logic ref_clk,
  input logic rst_n,
  input logic check_start,
  input logic check_ready,
  input logic check_valid,
  input logic done_ok,
  input logic reg_clock_pin,
  input logic async_gate_high,
  input logic gate_overdrive_level,
  input logic fuse_blow_supply,
  input logic [7:0] supply_bit_sel,
  input logic load_sel,
  input logic power_on
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int pcnt;
  // Length of the current overdrive pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pcnt <= 0;
    else pcnt <= gate_overdrive_level ? pcnt + 1 : 0;
  end
  sequence s_read_take;
    check_start && check_ready;
  endsequence
  sequence s_pulse_end;
    $fell(gate_overdrive_level);
  endsequence
  chk_gate_then_supply: assert property (fuse_blow_supply |-> async_gate_high)
    else $error("supply on without gate high");
  chk_overdrive_order: assert property ($rose(gate_overdrive_level) |->
    $past(fuse_blow_supply, 2) && async_gate_high)
    else $error("overdrive raised out of order");
  chk_pulse_len: assert property (s_pulse_end |-> pcnt == FIRST_CYC || pcnt == NEXT_CYC)
    else $error("pulse length wrong");
  chk_load_quiet: assert property (load_sel |-> !fuse_blow_supply && !gate_overdrive_level)
    else $error("load switched in while supply on");
  chk_sense_clocked: assert property (check_valid || done_ok |->
    $past(reg_clock_pin) && !$past(reg_clock_pin, 11))
    else $error("sense without clock edge");
  chk_load_on_sense: assert property (done_ok |-> $past(load_sel))
    else $error("sense without load switched in");
  chk_one_fuse: assert property (fuse_blow_supply |-> $onehot(supply_bit_sel))
    else $error("supply on more than one output");
  chk_cool_dark: assert property (!power_on |-> !fuse_blow_supply && !gate_overdrive_level)
    else $error("programming during cool-down");
  chk_read_time: assert property (s_read_take |-> ##16 check_valid)
    else $error("read answer late");
endmodule

bind fpp_programmer fpp_programmer_chk #(.FIRST_CYC(FIRST_CYC), .NEXT_CYC(NEXT_CYC)) u_chk (
  .ref_clk, .rst_n, .check_start, .check_ready, .check_valid, .done_ok, .reg_clock_pin,
  .async_gate_high, .gate_overdrive_level, .fuse_blow_supply, .supply_bit_sel, .load_sel,
  .power_on);

// ---- sim/fpp_prom_model.sv ----
// Behavioural registered fuse PROM on the programmer's pins
module fpp_prom_model (
  input wire [8:0] word_sel_lines,
  input wire reg_clock_pin,
  input wire sync_output_gate,
  input wire async_gate_high,
  input wire gate_overdrive_level,
  input wire fuse_blow_supply,
  input wire [7:0] supply_bit_sel,
  input wire [7:0] need,
  output logic [7:0] data_out_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:511];
  logic [7:0] last = 8'h00;
  logic off = 1'b1;
  logic [16:0] key = 17'h00000;
  int hits = 0;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  end
  // Off outputs show no stale data, so the inverse is driven
  assign data_out_bus = (off || async_gate_high) ? ~last : last;
  // Strong fuses need several pulses; need of FF opens only after 255 pulses
  // Current flows once overdrive meets a supply raised beforehand
  always @(posedge gate_overdrive_level) begin
    if (fuse_blow_supply) begin
      if (key !== {word_sel_lines, supply_bit_sel}) hits = 0;
      key = {word_sel_lines, supply_bit_sel};
      hits = hits + 1;
      if (hits >= need) mem[word_sel_lines] = mem[word_sel_lines] | supply_bit_sel;
    end
  end
  always @(posedge reg_clock_pin) begin
    off = sync_output_gate;
    if (!sync_output_gate) last = mem[word_sel_lines];
  end
endmodule

// ---- sim/test_fuse_prom_program_verify.sv ----
// Self-checking bench for the fuse programmer with a PROM model
module test_fuse_prom_program_verify;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [8:0] a; logic [2:0] b; logic [7:0] n; logic [7:0] q;} fpp_row_t;
  fpp_row_t rows [4] = '{'{9'h000, 3'h0, 8'h01, 8'h01}, '{9'h000, 3'h7, 8'h01, 8'h81},
    '{9'h1FF, 3'h3, 8'h02, 8'h08}, '{9'h0AA, 3'h5, 8'h03, 8'h20}};
  logic ref_clk = 0, rst_n = 0, prog_start = 0, check_start = 0, saw_cool = 0;
  logic [8:0] prog_addr = 9'h000, check_addr = 9'h000, word_sel_lines;
  logic [2:0] prog_bit = 3'h0;
  logic [7:0] need = 8'h01, check_data, supply_bit_sel, data_out_bus;
  logic prog_ready, check_ready, check_valid, done_ok, done_fail, reg_clock_pin;
  logic sync_output_gate, async_gate_high, gate_overdrive_level, fuse_blow_supply;
  logic load_sel, power_on;
  int error_cnt = 0, samples_checked = 0;
  // Short limits keep the run brief
  fpp_programmer #(.NEXT_CYC(200), .BIT_LIMIT_CYC(2000), .HOT_LIMIT_CYC(3000),
    .COOL_CYC(500)) u_dut (.ref_clk, .rst_n, .prog_start, .prog_addr, .prog_bit,
    .prog_ready, .check_start, .check_addr, .check_ready, .check_data, .check_valid,
    .done_ok, .done_fail, .word_sel_lines, .reg_clock_pin, .sync_output_gate,
    .async_gate_high, .gate_overdrive_level, .fuse_blow_supply, .supply_bit_sel,
    .load_sel, .power_on, .data_out_bus);
  fpp_prom_model u_prom (.word_sel_lines, .reg_clock_pin, .sync_output_gate, .async_gate_high,
    .gate_overdrive_level, .fuse_blow_supply, .supply_bit_sel, .need, .data_out_bus);
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (power_on === 1'b0) saw_cool <= 1'b1;
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic prog(logic [8:0] a, logic [2:0] b, logic [7:0] n, logic [1:0] exp);
    int k;
    @(posedge ref_clk);
    prog_start <= 1'b1;
    prog_addr <= a;
    prog_bit <= b;
    need <= n;
    @(negedge ref_clk);
    while (prog_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    prog_start <= 1'b0;
    k = 0;
    while (done_ok !== 1'b1 && done_fail !== 1'b1 && k < 5000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("done_ok_fail", exp, {done_ok, done_fail});
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] q);
    int k;
    @(posedge ref_clk);
    check_start <= 1'b1;
    check_addr <= a;
    @(negedge ref_clk);
    while (check_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    check_start <= 1'b0;
    k = 0;
    while (check_valid !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    chk("read_latency", 16, k);
    chk("check_data", q, check_data);
  endtask
  // Hang guard at 60000 cycles, well beyond the expected 7000 cycles
  initial begin
    #6000000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      prog(rows[i].a, rows[i].b, rows[i].n, 2'h2);
      rd(rows[i].a, rows[i].q);
    end
    prog(9'h055, 3'h2, 8'hFF, 2'h1);
    prog(9'h056, 3'h1, 8'h01, 2'h1);
    rd(9'h056, 8'h00);
    rd(9'h055, 8'h00);
    chk("cool_down_seen", 1, saw_cool);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(negedge ref_clk);
    chk("sync_output_gate", 1, sync_output_gate);
    chk("fuse_blow_supply", 0, fuse_blow_supply);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(9'h000, 8'h81);
    rd(9'h155, 8'h00);
    end_of_test();
  end
endmodule
